/* File: ulb_pkg.sv */
// Shared constants and state types for the serial transceiver with break
package ulb_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLOCK_PERIOD_NS  = 5;
	// Baud ticks per bit time (oversampling of the baud enable)
	localparam logic [3:0]  TICKS_LAST       = 4'h000F;
	localparam logic [3:0]  TICKS_MID        = 4'h0007;
	// Extra idle between back-to-back frames, in ns, rounded up to clock periods
	localparam int unsigned TX_GAP_NS        = 10;
	localparam logic [1:0]  TX_GAP_CYCLES    =
		2'((TX_GAP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

	// ------------------------------------------------------------
	// Frame and break figures
	// ------------------------------------------------------------
	localparam logic [4:0]  BREAK_TX_BASE    = 5'h000D;
	localparam logic [4:0]  BREAK_RX_MIN     = 5'h000B;
	localparam logic [4:0]  BREAK_RX_SAT     = 5'h001F;
	localparam logic [3:0]  CHAR_BITS_LONG   = 4'h0008;
	localparam logic [3:0]  CHAR_BITS_SHORT  = 4'h0007;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  TX_DATA_RESET    = 8'h00FF;
	localparam logic [7:0]  RX_DATA_RESET    = 8'h00FF;
	localparam logic [7:0]  RX_SHIFT_INIT    = 8'h00FF;

	// ------------------------------------------------------------
	// Parity modes and flag clear lanes
	// ------------------------------------------------------------
	localparam logic [1:0]  PARITY_NONE      = 2'h0;
	localparam logic [1:0]  PARITY_ZERO      = 2'h1;
	localparam logic [1:0]  PARITY_ODD       = 2'h2;
	localparam logic [1:0]  PARITY_EVEN      = 2'h3;
	localparam int unsigned CLR_OVERRUN      = 0;
	localparam int unsigned CLR_FRAMING      = 1;
	localparam int unsigned CLR_PARITY       = 2;

	// ------------------------------------------------------------
	// State machines
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE   = 3'b000,
		TX_START  = 3'b001,
		TX_DATA   = 3'b011,
		TX_PARITY = 3'b010,
		TX_STOP   = 3'b110,
		TX_GAP    = 3'b111,
		TX_BREAK  = 3'b101
	} ulb_tx_state_e;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_ARMED  = 3'b001,
		RX_START  = 3'b011,
		RX_DATA   = 3'b010,
		RX_PARITY = 3'b110,
		RX_STOP   = 3'b111,
		RX_BREAK  = 3'b101
	} ulb_rx_state_e;

endpackage : ulb_pkg

/* File: ulb_rx.sv */
// Receiver: start detection, data, error flags and break measurement
`timescale 1ns/1ps
module ulb_rx
	import ulb_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	input  wire logic       power_on_bit_in,
	input  wire logic       rx_enable_bit_in,
	input  wire logic       baud_tick_in,
	input  wire logic       serial_in_pin_in,
	input  wire logic       char_len8_in,
	input  wire logic [1:0] parity_mode_in,
	input  wire logic       msb_first_in,
	input  wire logic       break_rx_trigger_in,
	input  wire logic       rx_data_read_in,
	input  wire logic [2:0] status_clear_in,
	output logic      [7:0] rx_data_reg_out,
	output logic            parity_error_flag_out,
	output logic            framing_error_flag_out,
	output logic            overrun_flag_out,
	output logic            rx_done_irq_out,
	output logic            break_rx_active_flag_out
);

	// ------------------------------------------------------------
	// Bit timing
	// ------------------------------------------------------------
	ulb_rx_state_e state_reg;
	logic [3:0]    tick_reg;
	logic [4:0]    bit_reg;
	logic [7:0]    shift_reg;
	logic          par_bit_reg;
	logic          full_reg;
	logic          rx_on;
	logic          mid;
	logic          done;
	logic          pe_set;
	logic          fe_set;
	logic          ov_set;
	logic [7:0]    word;
	logic [3:0]    nbits;

	assign rx_on = power_on_bit_in && rx_enable_bit_in;
	assign mid   = baud_tick_in && (tick_reg == TICKS_MID);
	assign nbits = char_len8_in ? CHAR_BITS_LONG : CHAR_BITS_SHORT;

	always_comb begin
		if (char_len8_in)
			word = shift_reg;
		else if (msb_first_in)
			word = {shift_reg[6:0], 1'b0};
		else
			word = {1'b0, shift_reg[7:1]};
	end

	// Stop bit sampled: one stop bit only, a second is never looked at
	assign done   = (state_reg == RX_STOP) && mid;
	assign pe_set = done && parity_mode_in[1] &&
		((^word ^ par_bit_reg) == parity_mode_in[0]);
	assign fe_set = done && !serial_in_pin_in;
	assign ov_set = done && full_reg;

	// ------------------------------------------------------------
	// Receive state machine
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg   <= RX_IDLE;
			tick_reg    <= '0;
			bit_reg     <= '0;
			shift_reg   <= RX_SHIFT_INIT;
			par_bit_reg <= 1'b0;
		end else if (!rx_on) begin
			state_reg <= RX_IDLE;
			shift_reg <= RX_SHIFT_INIT;
		end else begin
			if (baud_tick_in)
				tick_reg <= (tick_reg == TICKS_LAST) ? '0 : tick_reg + 4'h0001;
			case (state_reg)
			RX_IDLE: begin
				// Line must be seen high before a falling edge counts
				if (serial_in_pin_in)
					state_reg <= RX_ARMED;
			end
			RX_ARMED: begin
				if (!serial_in_pin_in) begin
					state_reg <= RX_START;
					tick_reg  <= '0;
				end
			end
			RX_START: begin
				if (mid) begin
					bit_reg <= 5'h0001;
					// Glitch shorter than half a bit is dropped
					if (serial_in_pin_in)
						state_reg <= RX_IDLE;
					else if (break_rx_active_flag_out)
						state_reg <= RX_BREAK;
					else begin
						state_reg <= RX_DATA;
						shift_reg <= RX_SHIFT_INIT;
						bit_reg   <= '0;
					end
				end
			end
			RX_DATA: begin
				if (mid) begin
					if (msb_first_in)
						shift_reg <= {shift_reg[6:0], serial_in_pin_in};
					else
						shift_reg <= {serial_in_pin_in, shift_reg[7:1]};
					bit_reg <= bit_reg + 5'h0001;
					if (bit_reg[3:0] == nbits - 4'h0001)
						state_reg <= (parity_mode_in == PARITY_NONE) ?
							RX_STOP : RX_PARITY;
				end
			end
			RX_PARITY: begin
				if (mid) begin
					par_bit_reg <= serial_in_pin_in;
					state_reg   <= RX_STOP;
				end
			end
			RX_STOP: begin
				if (mid)
					state_reg <= RX_IDLE;
			end
			RX_BREAK: begin
				// Count whole low bit times, saturating
				if (mid) begin
					if (serial_in_pin_in)
						state_reg <= RX_IDLE;
					else if (bit_reg != BREAK_RX_SAT)
						bit_reg <= bit_reg + 5'h0001;
				end
			end
			default: state_reg <= RX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Data register and unread tracking
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_data_reg_out <= RX_DATA_RESET;
			full_reg        <= 1'b0;
		end else if (!power_on_bit_in) begin
			rx_data_reg_out <= RX_DATA_RESET;
			full_reg        <= 1'b0;
		end else if (done && !full_reg) begin
			rx_data_reg_out <= word;
			full_reg        <= 1'b1;
		end else if (rx_data_read_in || !rx_enable_bit_in) begin
			full_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Error flags: set beats a clear of the same cycle
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			parity_error_flag_out  <= 1'b0;
			framing_error_flag_out <= 1'b0;
			overrun_flag_out       <= 1'b0;
		end else if (!rx_on) begin
			parity_error_flag_out  <= 1'b0;
			framing_error_flag_out <= 1'b0;
			overrun_flag_out       <= 1'b0;
		end else begin
			if (pe_set)
				parity_error_flag_out <= 1'b1;
			else if (status_clear_in[CLR_PARITY])
				parity_error_flag_out <= 1'b0;
			if (fe_set)
				framing_error_flag_out <= 1'b1;
			else if (status_clear_in[CLR_FRAMING])
				framing_error_flag_out <= 1'b0;
			if (ov_set)
				overrun_flag_out <= 1'b1;
			else if (status_clear_in[CLR_OVERRUN])
				overrun_flag_out <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Break wait flag and completion pulse
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			break_rx_active_flag_out <= 1'b0;
			rx_done_irq_out          <= 1'b0;
		end else begin
			rx_done_irq_out <= rx_on && done;
			if (!rx_on)
				break_rx_active_flag_out <= 1'b0;
			else if (state_reg == RX_BREAK && mid && serial_in_pin_in &&
					bit_reg >= BREAK_RX_MIN) begin
				// Valid break: no data move, no error flags
				break_rx_active_flag_out <= 1'b0;
				rx_done_irq_out          <= 1'b1;
			end else if (break_rx_trigger_in)
				break_rx_active_flag_out <= 1'b1;
		end
	end

endmodule : ulb_rx

/* File: ulb_top.sv */
// Top of the serial transceiver: reset release, transmitter, receiver
`timescale 1ns/1ps
module ulb_top
	import ulb_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       resetn_in,
	input  wire logic       baud_tick_in,
	input  wire logic       power_on_bit_in,
	input  wire logic       tx_enable_bit_in,
	input  wire logic       rx_enable_bit_in,
	input  wire logic       char_len8_in,
	input  wire logic [1:0] parity_mode_in,
	input  wire logic       stop2_in,
	input  wire logic       msb_first_in,
	input  wire logic       tx_level_invert_in,
	input  wire logic [2:0] break_length_field_in,
	input  wire logic       tx_data_write_in,
	input  wire logic [7:0] tx_data_in,
	input  wire logic       break_tx_trigger_set_in,
	input  wire logic       break_rx_trigger_set_in,
	input  wire logic       rx_data_read_in,
	input  wire logic [2:0] status_clear_in,
	input  wire logic       serial_in_pin_in,
	output logic            serial_out_pin_out,
	output logic            tx_enable_irq_out,
	output logic            tx_busy_flag_out,
	output logic            break_tx_trigger_out,
	output logic      [7:0] tx_data_reg_out,
	output logic      [7:0] rx_data_reg_out,
	output logic            parity_error_flag_out,
	output logic            framing_error_flag_out,
	output logic            overrun_flag_out,
	output logic            rx_done_irq_out,
	output logic            break_rx_active_flag_out
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// ------------------------------------------------------------
	// Transmit timing
	// ------------------------------------------------------------
	ulb_tx_state_e tx_state_reg;
	logic [3:0]    tx_tick_reg;
	logic [4:0]    tx_bit_reg;
	logic [7:0]    tx_shift_reg;
	logic          tx_par_reg;
	logic          tx_pending_reg;
	logic [1:0]    tx_gap_reg;
	logic          tx_on;
	logic          bit_end;
	logic          tx_line;
	logic [3:0]    tx_nbits;
	logic [4:0]    break_bits;
	logic [7:0]    load_word;

	assign tx_on      = power_on_bit_in && tx_enable_bit_in;
	// Own tick counter, separate from the receiver's
	assign bit_end    = baud_tick_in && (tx_tick_reg == TICKS_LAST);
	assign tx_nbits   = char_len8_in ? CHAR_BITS_LONG : CHAR_BITS_SHORT;
	assign break_bits = BREAK_TX_BASE + {2'b00, break_length_field_in};
	// Unused bit of a 7-bit character is dropped for parity
	assign load_word  = char_len8_in ? tx_data_reg_out :
		(msb_first_in ? {tx_data_reg_out[7:1], 1'b0} :
		 {1'b0, tx_data_reg_out[6:0]});

	always_comb begin
		case (tx_state_reg)
		TX_START:  tx_line = 1'b0;
		TX_DATA:   tx_line = msb_first_in ? tx_shift_reg[7] : tx_shift_reg[0];
		TX_PARITY: tx_line = tx_par_reg;
		TX_BREAK:  tx_line = 1'b0;
		default:   tx_line = 1'b1;
		endcase
	end

	// ------------------------------------------------------------
	// Transmit data register and pending byte
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_data_reg_out <= TX_DATA_RESET;
			tx_pending_reg  <= 1'b0;
		end else begin
			if (tx_data_write_in)
				// A second write before the copy replaces the byte
				tx_data_reg_out <= tx_data_in;
			if (!tx_on)
				tx_pending_reg <= 1'b0;
			else if (tx_data_write_in)
				tx_pending_reg <= 1'b1;
			else if (tx_state_reg == TX_IDLE && !break_tx_trigger_out)
				tx_pending_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Break transmit trigger
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n)
			break_tx_trigger_out <= 1'b0;
		else if (!tx_on)
			break_tx_trigger_out <= 1'b0;
		else if (break_tx_trigger_set_in)
			break_tx_trigger_out <= 1'b1;
		else if (tx_state_reg == TX_BREAK && bit_end &&
				tx_bit_reg == break_bits - 5'h0001)
			break_tx_trigger_out <= 1'b0;
	end

	// ------------------------------------------------------------
	// Transmit state machine
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_reg <= TX_IDLE;
			tx_tick_reg  <= '0;
			tx_bit_reg   <= '0;
			tx_shift_reg <= TX_DATA_RESET;
			tx_par_reg   <= 1'b0;
			tx_gap_reg   <= '0;
		end else if (!tx_on) begin
			tx_state_reg <= TX_IDLE;
		end else begin
			if (baud_tick_in)
				tx_tick_reg <= bit_end ? '0 : tx_tick_reg + 4'h0001;
			case (tx_state_reg)
			TX_IDLE: begin
				tx_tick_reg <= '0;
				tx_bit_reg  <= '0;
				// Stays here after a break until new work
				if (break_tx_trigger_out)
					tx_state_reg <= TX_BREAK;
				else if (tx_pending_reg) begin
					tx_shift_reg <= load_word;
					case (parity_mode_in)
					PARITY_ODD:  tx_par_reg <= ~^load_word;
					PARITY_EVEN: tx_par_reg <= ^load_word;
					default:     tx_par_reg <= 1'b0;
					endcase
					tx_state_reg <= TX_START;
				end
			end
			TX_START: begin
				if (bit_end)
					tx_state_reg <= TX_DATA;
			end
			TX_DATA: begin
				if (bit_end) begin
					tx_shift_reg <= msb_first_in ? {tx_shift_reg[6:0], 1'b1} :
						{1'b1, tx_shift_reg[7:1]};
					tx_bit_reg <= tx_bit_reg + 5'h0001;
					if (tx_bit_reg[3:0] == tx_nbits - 4'h0001) begin
						tx_bit_reg   <= '0;
						tx_state_reg <= (parity_mode_in == PARITY_NONE) ?
							TX_STOP : TX_PARITY;
					end
				end
			end
			TX_PARITY: begin
				if (bit_end)
					tx_state_reg <= TX_STOP;
			end
			TX_STOP: begin
				if (bit_end) begin
					tx_bit_reg <= tx_bit_reg + 5'h0001;
					if (tx_bit_reg[0] == stop2_in) begin
						// Gap cycles plus the idle cycle give two extra clocks
						tx_gap_reg   <= TX_GAP_CYCLES - 2'h2;
						tx_state_reg <= tx_pending_reg ? TX_GAP : TX_IDLE;
					end
				end
			end
			TX_GAP: begin
				// Line stays high two clocks longer between frames
				if (tx_gap_reg == '0)
					tx_state_reg <= TX_IDLE;
				else
					tx_gap_reg <= tx_gap_reg - 2'h1;
			end
			TX_BREAK: begin
				if (bit_end) begin
					tx_bit_reg <= tx_bit_reg + 5'h0001;
					if (tx_bit_reg == break_bits - 5'h0001)
						tx_state_reg <= TX_IDLE;
				end
			end
			default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Transmit outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_pin_out <= 1'b1;
			tx_enable_irq_out  <= 1'b0;
			tx_busy_flag_out   <= 1'b0;
		end else begin
			// Powered down the pin idles high regardless of inversion
			serial_out_pin_out <= power_on_bit_in ?
				(tx_line ^ tx_level_invert_in) : 1'b1;
			tx_enable_irq_out  <= tx_on && tx_state_reg == TX_IDLE &&
				(break_tx_trigger_out || tx_pending_reg);
			tx_busy_flag_out   <= tx_on && (tx_pending_reg ||
				(tx_state_reg != TX_IDLE && tx_state_reg != TX_BREAK));
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	ulb_rx u_rx (
		.clock_in                 (clock_in),
		.rst_n_in                 (rst_n),
		.power_on_bit_in          (power_on_bit_in),
		.rx_enable_bit_in         (rx_enable_bit_in),
		.baud_tick_in             (baud_tick_in),
		.serial_in_pin_in         (serial_in_pin_in),
		.char_len8_in             (char_len8_in),
		.parity_mode_in           (parity_mode_in),
		.msb_first_in             (msb_first_in),
		.break_rx_trigger_in      (break_rx_trigger_set_in),
		.rx_data_read_in          (rx_data_read_in),
		.status_clear_in          (status_clear_in),
		.rx_data_reg_out          (rx_data_reg_out),
		.parity_error_flag_out    (parity_error_flag_out),
		.framing_error_flag_out   (framing_error_flag_out),
		.overrun_flag_out         (overrun_flag_out),
		.rx_done_irq_out          (rx_done_irq_out),
		.break_rx_active_flag_out (break_rx_active_flag_out)
	);

endmodule : ulb_top

/* File: ulb_chk.sv */
// Property checker for the serial transceiver top
`timescale 1ns/1ps
module ulb_chk (
	input wire logic       clock_in,
	input wire logic       resetn_in,
	input wire logic       power_on_bit_in,
	input wire logic       tx_enable_bit_in,
	input wire logic       rx_enable_bit_in,
	input wire logic       tx_level_invert_in,
	input wire logic       break_tx_trigger_set_in,
	input wire logic [2:0] status_clear_in,
	input wire logic       serial_out_pin_out,
	input wire logic       tx_enable_irq_out,
	input wire logic       tx_busy_flag_out,
	input wire logic       break_tx_trigger_out,
	input wire logic [7:0] rx_data_reg_out,
	input wire logic       framing_error_flag_out,
	input wire logic       overrun_flag_out,
	input wire logic       rx_done_irq_out,
	input wire logic       break_rx_active_flag_out
);
	// ------------------------------------------
	// Properties
	// ------------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!resetn_in);

	AST_TX_START: assert property (
		$rose(tx_busy_flag_out) |-> tx_enable_irq_out ##1
		serial_out_pin_out == tx_level_invert_in)
		else $error("frame start lacks irq or start bit");
	AST_BRK_LOW: assert property (
		$rose(break_tx_trigger_out) |=> tx_enable_irq_out ##1
		(serial_out_pin_out == tx_level_invert_in)[*8])
		else $error("break start lacks irq or low line");
	AST_BRK_ARM: assert property (
		$rose(break_tx_trigger_out) |-> $past(break_tx_trigger_set_in)
		&& $past(power_on_bit_in) && $past(tx_enable_bit_in))
		else $error("break trigger set without cause");
	AST_BRK_END: assert property (
		$fell(break_tx_trigger_out) && tx_enable_bit_in |-> ##[0:1]
		serial_out_pin_out != tx_level_invert_in)
		else $error("line not idle after break");
	AST_IDLE_HIGH: assert property (
		(power_on_bit_in && !tx_enable_bit_in && !tx_level_invert_in)[*3]
		|-> serial_out_pin_out)
		else $error("powered idle line not high");
	AST_BRK_RX: assert property (
		$fell(break_rx_active_flag_out) && rx_enable_bit_in &&
		power_on_bit_in |-> rx_done_irq_out && $stable({rx_data_reg_out,
		framing_error_flag_out, overrun_flag_out}))
		else $error("break end changed data or flags");
	AST_OVERRUN: assert property (
		$rose(overrun_flag_out) |-> rx_done_irq_out &&
		$stable(rx_data_reg_out))
		else $error("overrun replaced stored byte");
	AST_FRAME_ERR: assert property (
		$rose(framing_error_flag_out) |-> rx_done_irq_out)
		else $error("framing flag without irq");
	AST_STICKY: assert property (
		$fell(framing_error_flag_out) |-> $past(status_clear_in[1]) ||
		!$past(rx_enable_bit_in) || !$past(power_on_bit_in))
		else $error("framing flag cleared without cause");
endmodule : ulb_chk

bind ulb_top ulb_chk ulb_chk_inst (.*);

/* File: ulb_node.sv */
// Remote serial node model for the transceiver bench
`timescale 1ns/1ps
module ulb_node (
	input  wire logic clock_in,
	input  wire logic baud_tick_in,
	input  wire logic line_in,
	output logic      line_out
);
	initial line_out = 1'b1;
	task automatic ticks(input int k);
		repeat (k) do @(posedge clock_in); while (baud_tick_in !== 1'b1);
	endtask : ticks
	// Pulled-up line: idles high once a frame is done
	task automatic send(input logic [31:0] bits, input int k);
		for (int i = 0; i < k; i++) begin
			line_out <= bits[i];
			ticks(16);
		end
		// One idle bit so back-to-back frames never drive twice at once
		line_out <= 1'b1;
		ticks(16);
	endtask : send
	task automatic recv(input int k, output logic [31:0] bits);
		bits = '0;
		@(negedge line_in);
		ticks(8);
		for (int i = 0; i < k; i++) begin
			bits[i] = line_in;
			ticks(16);
		end
	endtask : recv
endmodule : ulb_node

/* File: ulb_tb.sv */
// Self-checking bench for the serial transceiver with break
`timescale 1ns/1ps
module testbench;
	import ulb_pkg::*;
	logic clock_in, resetn_in, baud_tick_in, power_on_bit_in;
	logic tx_enable_bit_in, rx_enable_bit_in, char_len8_in, stop2_in;
	logic msb_first_in, tx_level_invert_in, tx_data_write_in;
	logic break_tx_trigger_set_in, break_rx_trigger_set_in;
	logic rx_data_read_in, serial_in_pin_in, serial_out_pin_out;
	logic tx_enable_irq_out, tx_busy_flag_out, break_tx_trigger_out;
	logic parity_error_flag_out, framing_error_flag_out;
	logic overrun_flag_out, rx_done_irq_out, break_rx_active_flag_out;
	logic [1:0]  parity_mode_in;
	logic [2:0]  break_length_field_in, status_clear_in;
	logic [7:0]  tx_data_in, tx_data_reg_out, rx_data_reg_out, d;
	logic [31:0] got, fr;
	int          num_errors, checks, rx_irqs, n, cnt;
	ulb_top ulb_top_inst (.*);
	ulb_node ulb_node_inst (
		.clock_in     (clock_in),
		.baud_tick_in (baud_tick_in),
		.line_in      (serial_out_pin_out),
		.line_out     (serial_in_pin_in)
	);
	// ------------------------------------------
	// Helpers
	// ------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	task automatic cyc(input int k);
		repeat (k) @(negedge clock_in);
	endtask : cyc
	task automatic write(input logic [7:0] v);
		tx_data_in = v;
		tx_data_write_in = 1'b1;
		cyc(1);
		tx_data_write_in = 1'b0;
	endtask : write
	task automatic rd();
		rx_data_read_in = 1'b1;
		cyc(1);
		rx_data_read_in = 1'b0;
	endtask : rd
	// Counts half-sampled cycles the line stays at one level
	task automatic span(input logic lvl);
		cnt = 0;
		while (serial_out_pin_out === lvl) begin
			cnt++;
			cyc(1);
		end
	endtask : span
	function automatic logic [31:0] frame(input logic [7:0] v, output int k);
		logic b, p;
		frame = '0;
		k = 1;
		p = parity_mode_in == PARITY_ODD;
		for (int i = 0; i < (char_len8_in ? 8 : 7); i++) begin
			b = msb_first_in ? v[7 - i] : v[i];
			frame[k++] = b;
			p ^= b;
		end
		if (parity_mode_in != PARITY_NONE)
			frame[k++] = (parity_mode_in == PARITY_ZERO) ? 1'b0 : p;
		frame[k++] = 1'b1;
		if (stop2_in)
			frame[k++] = 1'b1;
	endfunction : frame
	// ------------------------------------------
	// Clock, baud tick, monitors
	// ------------------------------------------
	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	always @(negedge clock_in) baud_tick_in <= ~baud_tick_in;
	always @(posedge clock_in) if (rx_done_irq_out === 1'b1) rx_irqs++;
	initial begin
		#100_000;
		num_errors++;
		end_sim();
	end
	// ------------------------------------------
	// Tests
	// ------------------------------------------
	initial begin
		{resetn_in, baud_tick_in, power_on_bit_in, tx_enable_bit_in,
		 rx_enable_bit_in, char_len8_in, stop2_in, msb_first_in,
		 tx_level_invert_in, tx_data_write_in, break_tx_trigger_set_in,
		 break_rx_trigger_set_in, rx_data_read_in} = '0;
		{parity_mode_in, break_length_field_in, status_clear_in} = '0;
		tx_data_in = '0;
		cyc(3);
		resetn_in = 1'b1;
		cyc(3);
		power_on_bit_in = 1'b1;
		cyc(3);
		check(serial_out_pin_out, 1);
		tx_level_invert_in = 1'b1;
		cyc(3);
		check(serial_out_pin_out, 0);
		tx_level_invert_in = 1'b0;
		{tx_enable_bit_in, rx_enable_bit_in} = 2'b11;
		cyc(3);
		for (int m = 0; m < 4; m++) begin
			parity_mode_in = 2'(m);
			{char_len8_in, stop2_in, msb_first_in} = {m[0], m[0], m[1]};
			d = 8'(8'hA6 + 8'(m * 41));
			fr = frame(d, n);
			write(d);
			fork
				ulb_node_inst.recv(n, got);
				ulb_node_inst.send(fr, n);
			join
			check(got, fr);
			check(rx_data_reg_out, char_len8_in ? d : msb_first_in ?
				{d[7:1], 1'b0} : {1'b0, d[6:0]});
			check(rx_irqs, m + 1);
			rd();
		end
		{parity_mode_in, char_len8_in, stop2_in, msb_first_in} = 5'b11100;
		fr = frame(8'h01, n);
		ulb_node_inst.send(fr ^ 32'h200, n);
		check({parity_error_flag_out, rx_data_reg_out}, 9'h101);
		rd();
		ulb_node_inst.send(fr ^ 32'h400, n);
		check(framing_error_flag_out, 1);
		rd();
		ulb_node_inst.send(frame(8'h22, n), n);
		ulb_node_inst.send(frame(8'h44, n), n);
		check(rx_data_reg_out, 8'h22);
		check({parity_error_flag_out, framing_error_flag_out,
			overrun_flag_out, rx_irqs[3:0]}, 7'h78);
		status_clear_in = 3'b001;
		cyc(1);
		status_clear_in = 3'b000;
		cyc(1);
		check({parity_error_flag_out, framing_error_flag_out,
			overrun_flag_out}, 3'b110);
		rx_enable_bit_in = 1'b0;
		cyc(2);
		check({parity_error_flag_out, framing_error_flag_out}, 0);
		rx_enable_bit_in = 1'b1;
		// Zero data and forced-zero parity: the only rise is the stop bit
		parity_mode_in = PARITY_ZERO;
		write(8'h00);
		cyc(3);
		write(8'h00);
		@(posedge serial_out_pin_out);
		cyc(1);
		span(1'b1);
		check(cnt, 34);
		cyc(800);
		for (int f = 0; f < 8; f += 7) begin
			break_length_field_in = 3'(f);
			break_tx_trigger_set_in = 1'b1;
			cyc(1);
			break_tx_trigger_set_in = 1'b0;
			@(negedge serial_out_pin_out);
			cyc(1);
			span(1'b0);
			check(cnt >= (13 + f) * 32 - 2 && cnt <= (13 + f) * 32 + 2,
				1);
			check(break_tx_trigger_out, 0);
			cyc(100);
			check(serial_out_pin_out, 1);
		end
		tx_enable_bit_in = 1'b0;
		break_tx_trigger_set_in = 1'b1;
		cyc(1);
		break_tx_trigger_set_in = 1'b0;
		cyc(2);
		check(break_tx_trigger_out, 0);
		break_rx_trigger_set_in = 1'b1;
		cyc(1);
		break_rx_trigger_set_in = 1'b0;
		cyc(2);
		check(break_rx_active_flag_out, 1);
		ulb_node_inst.send(32'h0, 10);
		cyc(200);
		check({break_rx_active_flag_out, rx_irqs[3:0]}, 5'h18);
		ulb_node_inst.send(32'h0, 11);
		cyc(200);
		check({break_rx_active_flag_out, rx_irqs[3:0]}, 5'h09);
		check({framing_error_flag_out, overrun_flag_out,
			rx_data_reg_out}, 10'h022);
		end_sim();
	end
endmodule : testbench
